// ### inc/adp_params.svh
/*
  Constants of the audio digital path control block: register indices,
  reset values, field codes and timing counts.
  Assumes a 40 MHz pclk and inclusion by bare name from the design files.
*/
`ifndef ADP_PARAMS_SVH
`define ADP_PARAMS_SVH

`define ADP_IDX_DIG        10'h002
`define ADP_IDX_VOL        10'h003
`define ADP_IDX_LEFT       10'h004
`define ADP_IDX_RIGHT      10'h005
`define ADP_IDX_STAT       10'h020

`define ADP_DIG_RST        8'h14
`define ADP_VOL_RST        8'h80
`define ADP_LEVEL_RST      8'hcf

`define ADP_FMT_RJ24       3'h0
`define ADP_FMT_RJ20       3'h1
`define ADP_FMT_RJ18       3'h2
`define ADP_FMT_RJ16       3'h3
`define ADP_FMT_I2S        3'h4
`define ADP_FMT_LJ         3'h5

`define ADP_LEVEL_MUTE     8'h07
`define ADP_GAIN_BIAS      8'h03
`define ADP_GAIN_SHIFT     32
`define ADP_HPF_SHIFT      10

`define ADP_CLK_HZ         40000000
`define ADP_SS_MIN_HZ      32000
`define ADP_SS_MAX_HZ      48000
`define ADP_DS_MIN_HZ      88200
`define ADP_DS_MAX_HZ      96000
`define ADP_RATE_TOL_CYC   8

`endif

// ### inc/adp_pkg.sv
/*
  Types of the audio digital path control block.
  Assumes 24-bit audio samples.
*/
package adp_pkg;

  typedef struct packed {
    logic signed [23:0] left;
    logic signed [23:0] right;
  } adp_stereo_t;

  typedef struct packed {
    logic       highpass_skip;
    logic       rsvd;
    logic [1:0] boost;
    logic       speed_select;
    logic [2:0] fmt;
  } adp_dig_t;

  typedef struct packed {
    logic       fade;
    logic [4:0] rsvd;
    logic       mute_right;
    logic       mute_left;
  } adp_vol_t;

endpackage

// ### rtl/adp_fifo.sv
/*
  Synchronous FIFO with valid and ready on both sides.
  Assumes one clock and an active-low asynchronous reset.
*/
`timescale 1ns/100ps
module adp_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 32
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             in_valid,
  output      logic             in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output      logic             out_valid,
  input  wire logic             out_ready,
  output      logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH)
    begin : g_chk
      $error("FIFO depth must be a power of two, at least two.");
    end
  endgenerate

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr_reg;
  logic [AW:0]      rd_ptr_reg;
  logic             full;
  logic             empty;

  assign empty     = (wr_ptr_reg == rd_ptr_reg);
  assign full      = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
                     (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rd_ptr_reg[AW-1:0]];

  always_ff @(posedge pclk)
  begin
    if (in_valid && !full)
      mem[wr_ptr_reg[AW-1:0]] <= in_data;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wr_ptr_reg <= '0;
    else if (in_valid && !full)
      wr_ptr_reg <= wr_ptr_reg + 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rd_ptr_reg <= '0;
    else if (out_ready && !empty)
      rd_ptr_reg <= rd_ptr_reg + 1'b1;
  end

endmodule // adp_fifo

// ### rtl/adp_top.sv
/*
  Audio digital path: APB control registers, serial audio receiver,
  sample FIFO, high-pass filter, gain lift, volume with fade and mute.
  Assumes serial audio pins synchronous to pclk, bit clock well below pclk.
*/
// Added by the designer: the APB slave port.
`timescale 1ns/100ps
`include "adp_params.svh"
module adp_top #(
  parameter int DATA_W     = 24,
  parameter int FIFO_DEPTH = 32
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output      logic [31:0]         prdata,
  output      logic                pready,
  output      logic                pslverr,
  input  wire logic                sclk_in,
  input  wire logic                lrclk_in,
  input  wire logic                sdata_in,
  output      logic                out_valid,
  input  wire logic                out_ready,
  output      adp_pkg::adp_stereo_t out_sample,
  output      logic                mute_left_active,
  output      logic                mute_right_active
);

  generate
    if (DATA_W != 24)
    begin : g_chk
      $error("Sample width must be 24.");
    end
  endgenerate

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  adp_pkg::adp_dig_t dig_reg;
  adp_pkg::adp_vol_t vol_reg;
  logic [7:0]        level_reg [2];
  logic              overrun_reg;
  logic              rate_ok_reg;
  logic              fade_busy;
  logic              overrun_set;
  logic [9:0]        idx;
  logic              hit;
  logic              wr_en;
  logic [31:0]       rd_value;

  assign idx     = paddr[11:2];
  assign hit     = (paddr[1:0] == 2'h0) &&
                   (idx == `ADP_IDX_DIG || idx == `ADP_IDX_VOL || idx == `ADP_IDX_LEFT ||
                    idx == `ADP_IDX_RIGHT || idx == `ADP_IDX_STAT);
  assign wr_en   = psel && penable && pwrite && hit;
  assign pready  = psel && penable;
  assign pslverr = psel && penable && !hit;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dig_reg <= `ADP_DIG_RST;
      vol_reg <= `ADP_VOL_RST;
    end
    else if (wr_en)
    begin
      if (idx == `ADP_IDX_DIG)
        dig_reg <= {pwdata[7], 1'b0, pwdata[5:0]};
      if (idx == `ADP_IDX_VOL)
        vol_reg <= {pwdata[7], 5'h00, pwdata[1:0]};
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      level_reg[0] <= `ADP_LEVEL_RST;
      level_reg[1] <= `ADP_LEVEL_RST;
    end
    else if (wr_en)
    begin
      if (idx == `ADP_IDX_LEFT)
        level_reg[0] <= pwdata[7:0];
      if (idx == `ADP_IDX_RIGHT)
        level_reg[1] <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      overrun_reg <= 1'b0;
    else if (overrun_set)
      overrun_reg <= 1'b1;
    else if (wr_en && idx == `ADP_IDX_STAT && pwdata[3])
      overrun_reg <= 1'b0;
  end

  always_comb
  begin
    rd_value = 32'h0000_0000;
    unique case (idx)
      `ADP_IDX_DIG:   rd_value[7:0] = dig_reg;
      `ADP_IDX_VOL:   rd_value[7:0] = vol_reg;
      `ADP_IDX_LEFT:  rd_value[7:0] = level_reg[0];
      `ADP_IDX_RIGHT: rd_value[7:0] = level_reg[1];
      `ADP_IDX_STAT:  rd_value[4:0] = {fade_busy, overrun_reg, mute_right_active,
                                       mute_left_active, rate_ok_reg};
      default:        rd_value = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      prdata <= hit ? rd_value : 32'h0000_0000;
  end

  // ----------------------------------------------------------------
  // Serial audio receiver
  // ----------------------------------------------------------------
  logic                 sclk_prev_reg;
  logic                 lr_prev_reg;
  logic [31:0]          shift_reg;
  logic [23:0]          just_reg;
  logic [5:0]           bit_cnt_reg;
  logic [23:0]          left_hold_reg;
  adp_pkg::adp_stereo_t pend_reg;
  logic                 pend_valid_reg;
  logic                 fifo_in_ready;
  logic                 bit_tick;
  logic                 lr_change;
  logic                 fmt_i2s;
  logic                 fmt_rj;
  logic                 fmt_ok;
  logic                 word_left;
  logic [23:0]          word;
  logic [5:0]           just_pos;

  assign bit_tick  = sclk_in && !sclk_prev_reg;
  assign lr_change = bit_tick && (lrclk_in != lr_prev_reg);
  assign fmt_i2s   = (dig_reg.fmt == `ADP_FMT_I2S);
  assign fmt_rj    = (dig_reg.fmt <= `ADP_FMT_RJ16);
  assign fmt_ok    = (dig_reg.fmt <= `ADP_FMT_LJ);
  assign word_left = fmt_i2s ? !lr_prev_reg : lr_prev_reg;
  // I2S skips the first slot bit.
  assign just_pos  = fmt_i2s ? bit_cnt_reg - 6'd1 : bit_cnt_reg;

  always_comb
  begin
    unique case (dig_reg.fmt)
      `ADP_FMT_RJ24: word = shift_reg[23:0];
      `ADP_FMT_RJ20: word = {shift_reg[19:0], 4'h0};
      `ADP_FMT_RJ18: word = {shift_reg[17:0], 6'h00};
      `ADP_FMT_RJ16: word = {shift_reg[15:0], 8'h00};
      default:       word = just_reg;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sclk_prev_reg <= 1'b0;
      lr_prev_reg   <= 1'b0;
      shift_reg     <= 32'h0000_0000;
      just_reg      <= 24'h00_0000;
      bit_cnt_reg   <= 6'h00;
    end
    else
    begin
      sclk_prev_reg <= sclk_in;
      if (bit_tick)
      begin
        lr_prev_reg <= lrclk_in;
        shift_reg   <= {shift_reg[30:0], sdata_in};
        if (lr_change)
        begin
          bit_cnt_reg <= 6'd1;
          just_reg    <= {sdata_in && !fmt_i2s, 23'h00_0000};
        end
        else
        begin
          if (bit_cnt_reg != 6'h3f)
            bit_cnt_reg <= bit_cnt_reg + 6'd1;
          if (!fmt_rj && (!fmt_i2s || bit_cnt_reg != 6'd0) && just_pos < 6'd24)
            just_reg[5'd23 - just_pos[4:0]] <= sdata_in;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      left_hold_reg  <= 24'h00_0000;
      pend_reg       <= '0;
      pend_valid_reg <= 1'b0;
    end
    else
    begin
      if (pend_valid_reg && fifo_in_ready)
        pend_valid_reg <= 1'b0;
      if (lr_change && fmt_ok && rate_ok_reg)
      begin
        if (word_left)
          left_hold_reg <= word;
        else
        begin
          pend_reg       <= {left_hold_reg, word};
          pend_valid_reg <= 1'b1;
        end
      end
    end
  end

  assign overrun_set = lr_change && fmt_ok && rate_ok_reg && !word_left &&
                       pend_valid_reg && !fifo_in_ready;

  // ----------------------------------------------------------------
  // Sample rate check
  // ----------------------------------------------------------------
  localparam logic [12:0] SS_LO = 13'(`ADP_CLK_HZ / `ADP_SS_MAX_HZ - `ADP_RATE_TOL_CYC);
  localparam logic [12:0] SS_HI = 13'(`ADP_CLK_HZ / `ADP_SS_MIN_HZ + `ADP_RATE_TOL_CYC);
  localparam logic [12:0] DS_LO = 13'(`ADP_CLK_HZ / `ADP_DS_MAX_HZ - `ADP_RATE_TOL_CYC);
  localparam logic [12:0] DS_HI = 13'(`ADP_CLK_HZ / `ADP_DS_MIN_HZ + `ADP_RATE_TOL_CYC);

  logic [12:0] frame_cnt_reg;
  logic        frame_start;

  assign frame_start = lr_change && lrclk_in;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      frame_cnt_reg <= 13'h0000;
    else if (frame_start)
      frame_cnt_reg <= 13'h0001;
    else if (frame_cnt_reg != 13'h1fff)
      frame_cnt_reg <= frame_cnt_reg + 13'd1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rate_ok_reg <= 1'b0;
    else if (frame_start)
    begin
      if (dig_reg.speed_select)
        rate_ok_reg <= (frame_cnt_reg >= DS_LO) && (frame_cnt_reg <= DS_HI);
      else
        rate_ok_reg <= (frame_cnt_reg >= SS_LO) && (frame_cnt_reg <= SS_HI);
    end
    else if (frame_cnt_reg == 13'h1fff)
      rate_ok_reg <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Sample FIFO
  // ----------------------------------------------------------------
  adp_pkg::adp_stereo_t fifo_out;
  logic                 fifo_out_valid;
  logic                 pop;

  adp_fifo #(
    .WIDTH (2 * DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (pend_valid_reg),
    .in_ready  (fifo_in_ready),
    .in_data   (pend_reg),
    .out_valid (fifo_out_valid),
    .out_ready (pop),
    .out_data  (fifo_out)
  );

  assign pop = fifo_out_valid && (!out_valid || out_ready);

  // ----------------------------------------------------------------
  // Processing per channel
  // ----------------------------------------------------------------
  function automatic logic signed [23:0] adp_sat(input logic signed [63:0] v);
    if (v > 64'sh0000_0000_007f_ffff)
      adp_sat = 24'h7f_ffff;
    else if (v < -64'sh0000_0000_0080_0000)
      adp_sat = 24'h80_0000;
    else
      adp_sat = v[23:0];
  endfunction

  localparam logic [15:0] MANT [12] = '{16'h8000, 16'h879c, 16'h8fad, 16'h9838,
                                        16'ha145, 16'haadc, 16'hb505, 16'hbfc9,
                                        16'hcb30, 16'hd745, 16'he412, 16'hf1a2};

  logic signed [23:0] ch_in   [2];
  logic signed [23:0] ch_out  [2];
  logic [7:0]         cur_reg [2];
  logic [7:0]         target  [2];
  logic [1:0]         ch_mute;
  logic [1:0]         busy;

  assign ch_in[0]          = fifo_out.left;
  assign ch_in[1]          = fifo_out.right;
  assign ch_mute           = {vol_reg.mute_right, vol_reg.mute_left};
  assign fade_busy         = |busy;
  assign mute_right_active = (cur_reg[1] < `ADP_LEVEL_MUTE);
  assign mute_left_active  = (cur_reg[0] < `ADP_LEVEL_MUTE);

  for (genvar c = 0; c < 2; c++)
  begin : g_ch
    logic signed [24:0] x1_reg;
    logic signed [25:0] y1_reg;
    logic signed [25:0] y_next;
    logic signed [23:0] hp;
    logic signed [23:0] lifted;
    logic [7:0]         u;
    logic [4:0]         q;
    logic [3:0]         r;
    logic signed [63:0] prod;

    assign y_next = 26'(ch_in[c]) - 26'(x1_reg) + y1_reg - (y1_reg >>> `ADP_HPF_SHIFT);
    assign hp     = dig_reg.highpass_skip ? ch_in[c] : adp_sat(64'(y_next));
    assign lifted = adp_sat(64'(hp) <<< dig_reg.boost);
    assign u      = cur_reg[c] - `ADP_GAIN_BIAS;
    assign q      = 5'(u / 8'd12);
    assign r      = 4'(u % 8'd12);
    assign prod   = (64'(lifted) * 64'(MANT[r])) <<< q;
    assign ch_out[c] = (cur_reg[c] < `ADP_LEVEL_MUTE) ? 24'h00_0000 :
                       adp_sat(prod >>> `ADP_GAIN_SHIFT);
    assign target[c] = (ch_mute[c] || level_reg[c] < `ADP_LEVEL_MUTE) ? 8'h00 : level_reg[c];
    assign busy[c]   = (cur_reg[c] != target[c]);

    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        x1_reg <= 25'h000_0000;
        y1_reg <= 26'h000_0000;
      end
      else if (pop)
      begin
        x1_reg <= 25'(ch_in[c]);
        y1_reg <= y_next;
      end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        cur_reg[c] <= `ADP_LEVEL_RST;
      else if (!vol_reg.fade)
        cur_reg[c] <= target[c];
      else if (pop && busy[c])
      begin
        if (target[c] == 8'h00 && cur_reg[c] <= `ADP_LEVEL_MUTE)
          cur_reg[c] <= 8'h00;
        else if (cur_reg[c] < `ADP_LEVEL_MUTE)
          cur_reg[c] <= `ADP_LEVEL_MUTE;
        else if (cur_reg[c] < target[c])
          cur_reg[c] <= cur_reg[c] + 8'd1;
        else
          cur_reg[c] <= cur_reg[c] - 8'd1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Output stage
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      out_valid  <= 1'b0;
      out_sample <= '0;
    end
    else if (pop)
    begin
      out_valid  <= 1'b1;
      out_sample <= {ch_out[0], ch_out[1]};
    end
    else if (out_ready)
      out_valid <= 1'b0;
  end

endmodule // adp_top

// ### tb/adp_i2s_src.sv
/* Serial audio source: bit clock, word clock and data.
   Assumes all timing is counted in pclk cycles. */
`timescale 1ns/100ps
module adp_i2s_src (
  input  wire logic        pclk,
  input  wire logic [3:0]  half,
  input  wire logic [2:0]  fmt,
  input  wire logic [23:0] left_s,
  input  wire logic [23:0] right_s,
  output      logic        sclk_out,
  output      logic        lrclk_out,
  output      logic        sdata_out,
  output      logic        pair_done
);
  // --------------------------------
  // Frame generator
  // --------------------------------
  logic [23:0] s[2];
  int          w;
  int          off;
  initial
  begin
    sclk_out = 1'b0;
    lrclk_out = 1'b0;
    sdata_out = 1'b0;
    pair_done = 1'b0;
  end
  always
  begin
    @(posedge pclk);
    s[0] = left_s;
    s[1] = right_s;
    w = (fmt == 3'h1) ? 20 : (fmt == 3'h2) ? 18 : (fmt == 3'h3) ? 16 : 24;
    off = (fmt == 3'h4) ? 1 : (fmt == 3'h5) ? 0 : 27 - w;
    for (int ch = 0; ch < 2; ch++)
      for (int k = 0; k < 27; k++)
      begin
        sclk_out <= 1'b0;
        lrclk_out <= (ch == 0) ^ (fmt == 3'h4);
        sdata_out <= (k >= off && k < off + w) ? s[ch][23 - (k - off)] : k[0];
        repeat (half) @(posedge pclk);
        sclk_out <= 1'b1;
        repeat (half) @(posedge pclk);
      end
    pair_done <= 1'b1;
    @(posedge pclk);
    pair_done <= 1'b0;
  end
endmodule // adp_i2s_src

// ### tb/adp_monitor.sv
/* Port checker for adp_top.
   Assumes a bind onto adp_top and one clock domain. */
`timescale 1ns/100ps
`include "adp_params.svh"
module adp_monitor #(
  parameter int FIFO_DEPTH = 32
) (
  input wire logic                 pclk,
  input wire logic                 presetn,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [11:0]          paddr,
  input wire logic [31:0]          pwdata,
  input wire logic [31:0]          prdata,
  input wire logic                 pready,
  input wire logic                 pslverr,
  input wire logic                 sclk_in,
  input wire logic                 lrclk_in,
  input wire logic                 sdata_in,
  input wire logic                 out_valid,
  input wire logic                 out_ready,
  input wire adp_pkg::adp_stereo_t out_sample,
  input wire logic                 mute_left_active,
  input wire logic                 mute_right_active
);
  // --------------------------------
  // Checks
  // --------------------------------
  logic rd_acc;
  assign rd_acc = psel && penable && !pwrite;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_ready_zero_wait: assert property (psel && penable |-> pready)
    else $error("pready late");
  a_ready_idle: assert property (!psel |-> !pready && !pslverr)
    else $error("answer while idle");
  a_err_unaligned: assert property (psel && penable && paddr[1:0] != 2'b00 |-> pslverr)
    else $error("unaligned not refused");
  a_err_mapped: assert property (psel && penable && paddr == {`ADP_IDX_LEFT, 2'b00} |-> !pslverr)
    else $error("mapped refused");
  a_err_read_zero: assert property (rd_acc && pslverr |-> prdata == 32'h0000_0000)
    else $error("refused read not zero");
  a_rdata_held: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("read data moved");
  a_vol_rsvd_zero: assert property (rd_acc && paddr == {`ADP_IDX_VOL, 2'b00} |-> prdata[6:2] == 5'h00)
    else $error("volume reserved set");
  a_dig_rsvd_zero: assert property (rd_acc && paddr == {`ADP_IDX_DIG, 2'b00} |-> !prdata[6])
    else $error("control reserved set");
  a_sample_held: assert property (out_valid && !out_ready |=> out_valid && $stable(out_sample))
    else $error("sample dropped while stalled");
  c_read: cover property (rd_acc);
  c_refused: cover property (pslverr);
  c_stall: cover property (out_valid && !out_ready);
  c_mute: cover property (mute_left_active);
endmodule // adp_monitor

bind adp_top adp_monitor #(.FIFO_DEPTH(FIFO_DEPTH)) u_mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .sclk_in(sclk_in), .lrclk_in(lrclk_in), .sdata_in(sdata_in), .out_valid(out_valid),
  .out_ready(out_ready), .out_sample(out_sample), .mute_left_active(mute_left_active),
  .mute_right_active(mute_right_active)
);

// ### tb/audio_digital_path_controls_tb.sv
/* Self-checking bench for adp_top.
   Assumes adp_params.svh on the include path. */
`timescale 1ns/100ps
`include "adp_params.svh"
module audio_digital_path_controls_tb;
  // --------------------------------
  // Stimulus and checking
  // --------------------------------
  localparam logic [11:0] A_DIG = {`ADP_IDX_DIG, 2'b00};
  localparam logic [11:0] A_VOL = {`ADP_IDX_VOL, 2'b00};
  localparam logic [11:0] A_LFT = {`ADP_IDX_LEFT, 2'b00};
  localparam logic [11:0] A_RGT = {`ADP_IDX_RIGHT, 2'b00};
  localparam logic [11:0] A_STA = {`ADP_IDX_STAT, 2'b00};
  logic                 pclk = 1'b0;
  logic                 presetn, psel, penable, pwrite, pready, pslverr;
  logic                 out_valid, out_ready, sclk_w, lrclk_w, sdata_w;
  logic                 pair_done, mute_l, mute_r, stall, rec, hold, zl, zr;
  logic [11:0]          paddr;
  logic [31:0]          pwdata, prdata, rnd;
  logic [3:0]           half;
  logic [2:0]           fmt;
  logic [23:0]          src_l, src_r;
  adp_pkg::adp_stereo_t out_sample;
  adp_pkg::adp_stereo_t sq[$];
  logic [15:0]          rq[$];
  int                   errors = 0, compares = 0, seed = 77853, npairs = 0, shl, shr;

  always #12.5 pclk = ~pclk;

  adp_top dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sclk_in(sclk_w), .lrclk_in(lrclk_w), .sdata_in(sdata_w), .out_valid(out_valid),
    .out_ready(out_ready), .out_sample(out_sample), .mute_left_active(mute_l),
    .mute_right_active(mute_r)
  );
  adp_i2s_src src (
    .pclk(pclk), .half(half), .fmt(fmt), .left_s(src_l), .right_s(src_r),
    .sclk_out(sclk_w), .lrclk_out(lrclk_w), .sdata_out(sdata_w), .pair_done(pair_done)
  );

  task automatic end_sim;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic bad(input string m);
    errors++;
    $display("mismatch at %0t: %s", $time, m);
  endtask

  task automatic chk(input logic g, input logic e, input string m);
    compares++;
    if (g !== e)
      bad(m);
  endtask

  function automatic logic [23:0] sc(input logic [23:0] x, input int s, input logic z);
    if (z)
      return 24'h00_0000;
    if (s < 0)
      return $signed(x) >>> (-s);
    return x << s;
  endfunction

  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      bad("bus timeout");
      end_sim;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] m, input logic [7:0] v);
    rq.push_back({m, v});
    apb(1'b0, a, 8'h00);
  endtask

  task automatic pairs(input int n);
    int t;
    t = npairs + n;
    for (int i = 0; i < 2000 * n && npairs < t; i++)
      @(posedge pclk);
    if (npairs < t)
    begin
      bad("no frames");
      end_sim;
    end
  endtask

  task automatic cfg(input logic [7:0] d, v, l, r, input int sl, sr);
    half <= d[3] ? 4'h4 : 4'h8;
    fmt <= d[2:0];
    shl <= d[5:4] + sl;
    shr <= d[5:4] + sr;
    zl <= v[0] || l < 8'h07;
    zr <= v[1] || r < 8'h07;
    apb(1'b1, A_DIG, d);
    apb(1'b1, A_VOL, v);
    apb(1'b1, A_LFT, l);
    apb(1'b1, A_RGT, r);
    pairs(4);
    rec <= 1'b1;
    pairs(3);
    rec <= 1'b0;
    pairs(1);
    chk(sq.size() == 0, 1'b1, "sample missing");
    sq.delete();
  endtask

  always @(posedge pclk)
  begin
    out_ready <= !stall && ($random(seed) % 4 != 0);
    if (pair_done === 1'b1)
    begin
      if (rec)
        sq.push_back({sc(src_l, shl, zl), sc(src_r, shr, zr)});
      rnd = $random(seed);
      src_l <= hold ? 24'h04_0000 : {{4{rnd[19]}}, rnd[19:8], 8'h00};
      src_r <= hold ? 24'h04_0000 : {{4{rnd[31]}}, rnd[31:20], 8'h00};
      npairs <= npairs + 1;
    end
    if (psel && penable && pready === 1'b1)
    begin
      compares++;
      if (pslverr !== !(paddr inside {A_DIG, A_VOL, A_LFT, A_RGT, A_STA}))
        bad("bus error flag");
    end
    if (psel && penable && !pwrite && pready === 1'b1 && rq.size() > 0)
    begin
      compares++;
      if ((prdata & {24'hff_ffff, rq[0][15:8]}) !== {24'h00_0000, rq[0][7:0]})
        bad("register read");
      rq.delete(0);
    end
    if (out_valid === 1'b1 && out_ready && sq.size() > 0)
    begin
      compares++;
      if (out_sample !== sq[0])
        bad("stream sample");
      sq.delete(0);
    end
  end

  initial
  begin
    presetn = 1'b0;
    {psel, penable, pwrite, out_ready, stall, rec, hold} = 7'h00;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    {half, fmt, shl, shr, zl, zr} = {4'h8, 3'h4, 64'h0, 2'b00};
    {src_l, src_r} = 48'h0000_0000_0000;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(A_DIG, 8'hff, 8'h14);
    rd(A_VOL, 8'hff, 8'h80);
    rd(A_LFT, 8'hff, 8'hcf);
    rd(A_RGT, 8'hff, 8'hcf);
    apb(1'b1, A_DIG, 8'hff);
    rd(A_DIG, 8'hff, 8'hbf);
    apb(1'b1, A_VOL, 8'h7c);
    rd(A_VOL, 8'hff, 8'h00);
    apb(1'b1, 12'h01c, 8'h55);
    rd(12'h01c, 8'hff, 8'h00);
    rd(12'h011, 8'hff, 8'h00);
    for (int f = 0; f < 6; f++)
      cfg(8'h88 | f, 8'h00, 8'hcf, 8'hcf, 0, 0);
    for (int b = 1; b < 4; b++)
      cfg(8'h8c | (b << 4), 8'h00, 8'hcf, 8'hcf, 0, 0);
    cfg(8'h8c, 8'h00, 8'hc3, 8'hdb, -1, 1);
    cfg(8'h8c, 8'h00, 8'h06, 8'hcf, 0, 0);
    cfg(8'h8c, 8'h01, 8'hcf, 8'hcf, 0, 0);
    chk(mute_l, 1'b1, "left mute flag");
    cfg(8'h8c, 8'h02, 8'hcf, 8'hcf, 0, 0);
    chk(mute_r, 1'b1, "right mute flag");
    chk(mute_l, 1'b0, "left mute stuck");
    apb(1'b1, A_DIG, 8'h84);
    pairs(4);
    rd(A_STA, 8'h01, 8'h00);
    cfg(8'h84, 8'h00, 8'hcf, 8'hcf, 0, 0);
    rd(A_STA, 8'h01, 8'h01);
    cfg(8'h8c, 8'h00, 8'hcf, 8'hcf, 0, 0);
    hold <= 1'b1;
    apb(1'b1, A_DIG, 8'h0c);
    pairs(6);
    for (int i = 0; i < 1000 && out_valid !== 1'b1; i++)
      @(posedge pclk);
    if (out_valid !== 1'b1)
    begin
      bad("no output sample");
      end_sim;
    end
    chk(out_sample.left !== 24'h04_0000, 1'b1, "filter skipped");
    hold <= 1'b0;
    apb(1'b1, A_VOL, 8'h80);
    apb(1'b1, A_LFT, 8'h06);
    rd(A_STA, 8'h12, 8'h10);
    chk(mute_l, 1'b0, "fade stepped at once");
    apb(1'b1, A_LFT, 8'hcf);
    pairs(8);
    rd(A_STA, 8'h10, 8'h00);
    stall <= 1'b1;
    pairs(40);
    rd(A_STA, 8'h08, 8'h08);
    stall <= 1'b0;
    pairs(3);
    apb(1'b1, A_STA, 8'h08);
    rd(A_STA, 8'h08, 8'h00);
    end_sim;
  end
endmodule // audio_digital_path_controls_tb
